//--- core/aux_led_defines.svh
`ifndef AUX_LED_DEFINES_SVH
`define AUX_LED_DEFINES_SVH

// ****************************************
// register offsets
// ****************************************
`define AUX_OFS_SINK_CTRL 8'h11
`define AUX_OFS_FADE 8'h13
`define AUX_OFS_SINK0_LEVEL 8'h14
`define AUX_OFS_SINK1_LEVEL 8'h15
`define AUX_OFS_SINK2_LEVEL 8'h16

// ****************************************
// field positions
// ****************************************
`define AUX_FO_MSB 7
`define AUX_FO_LSB 4
`define AUX_FI_MSB 3
`define AUX_FI_LSB 0
`define AUX_LEVEL_MSB 5
`define AUX_LAW_BIT 3
`define AUX_EN_MSB 2

// ****************************************
// reset values
// ****************************************
`define AUX_RST_CTRL 4'h0
`define AUX_RST_FADE 8'h00
`define AUX_RST_LEVEL 6'h00

// ****************************************
// timing
// ****************************************
// fade durations are counted in units of 0.1 s
`define AUX_FADE_UNIT_MS 100
`define AUX_CLK_KHZ 125000
`define AUX_RAMP_STEPS 64
// sub tick: 1/64 of a fade unit, each ramp step takes one sub tick per fade unit of duration
`define AUX_SUBTICK_CYC ((`AUX_FADE_UNIT_MS * `AUX_CLK_KHZ) / `AUX_RAMP_STEPS)
`define AUX_RAMP_FULL 7'h40
`define AUX_LAST_SHORT_CODE 4'hA
`define AUX_SHORT_UNITS 6'h03
`define AUX_LONG_BASE_UNITS 6'h23
`define AUX_LONG_UNITS 6'h05
`define AUX_FIRST_LONG_CODE 6'h0B

`endif

//--- core/aux_led_pkg.sv
package aux_led_pkg;

	// ****************************************
	// shared types
	// ****************************************
	typedef logic [5:0] level_t;

	typedef struct packed {
		logic law;
		logic en;
		level_t level;
		logic [3:0] fade_in_duration;
		logic [3:0] fade_out_duration;
	} sink_ctrl_t;

	typedef enum logic [3:0] {
		ST_OFF = 4'b0001,
		ST_RISE = 4'b0010,
		ST_ON = 4'b0100,
		ST_FALL = 4'b1000
	} ramp_state_t;

endpackage : aux_led_pkg

//--- core/aux_sink_ramp.sv
`timescale 1ns/100ps
`include "aux_led_defines.svh"

module aux_sink_ramp
	import aux_led_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic sub_tick,
	input sink_ctrl_t ctrl,
	output level_t sink_code
);

	// ****************************************
	// duration decode
	// ****************************************
	// code to duration in 0.1 s units, zero means no fade
	function automatic logic [5:0] dur_units(input logic [3:0] code);
		logic [5:0] c;
		c = {2'h0, code};
		if (code <= `AUX_LAST_SHORT_CODE) begin
			dur_units = c * `AUX_SHORT_UNITS;
		end else begin
			dur_units = `AUX_LONG_BASE_UNITS +
				(c - `AUX_FIRST_LONG_CODE) * `AUX_LONG_UNITS;
		end
	endfunction : dur_units

	ramp_state_t state_q, state_d;
	logic [6:0] pos_q, pos_d;
	logic [5:0] cnt_q, cnt_d;
	level_t code_q, code_d;
	logic [5:0] fi_units, fo_units;
	logic [12:0] lin;
	logic [17:0] sq;

	assign fi_units = dur_units(ctrl.fade_in_duration);
	assign fo_units = dur_units(ctrl.fade_out_duration);

	// ****************************************
	// ramp sequencer
	// ****************************************
	// next state, position and step counter
	always_comb begin
		state_d = state_q;
		pos_d = pos_q;
		cnt_d = cnt_q;
		case (state_q)
			ST_OFF: begin
				if (ctrl.en && fi_units == 6'h00) begin
					pos_d = `AUX_RAMP_FULL;
					state_d = ST_ON;
				end else if (ctrl.en) begin
					cnt_d = 6'h00;
					state_d = ST_RISE;
				end
			end
			ST_RISE: begin
				if (!ctrl.en && fo_units == 6'h00) begin
					pos_d = 7'h00;
					state_d = ST_OFF;
				end else if (!ctrl.en) begin
					cnt_d = 6'h00;
					state_d = ST_FALL;
				end else if (fi_units == 6'h00) begin
					pos_d = `AUX_RAMP_FULL;
					state_d = ST_ON;
				end else if (sub_tick && cnt_q + 6'h01 >= fi_units) begin
					cnt_d = 6'h00;
					pos_d = pos_q + 7'h01;
					if (pos_q == `AUX_RAMP_FULL - 7'h01) begin
						state_d = ST_ON;
					end
				end else if (sub_tick) begin
					cnt_d = cnt_q + 6'h01;
				end
			end
			ST_ON: begin
				if (!ctrl.en && fo_units == 6'h00) begin
					pos_d = 7'h00;
					state_d = ST_OFF;
				end else if (!ctrl.en) begin
					cnt_d = 6'h00;
					state_d = ST_FALL;
				end
			end
			ST_FALL: begin
				if (ctrl.en) begin
					cnt_d = 6'h00;
					state_d = ST_RISE;
				end else if (fo_units == 6'h00) begin
					pos_d = 7'h00;
					state_d = ST_OFF;
				end else if (sub_tick && cnt_q + 6'h01 >= fo_units) begin
					cnt_d = 6'h00;
					pos_d = pos_q - 7'h01;
					if (pos_q == 7'h01) begin
						state_d = ST_OFF;
					end
				end else if (sub_tick) begin
					cnt_d = cnt_q + 6'h01;
				end
			end
			default: begin
				pos_d = 7'h00;
				state_d = ST_OFF;
			end
		endcase
	end

	// ramp shape scaling of the target level
	assign lin = {7'h00, ctrl.level} * {6'h00, pos_q};
	assign sq = {12'h000, ctrl.level} * {11'h000, pos_q} * {11'h000, pos_q};

	always_comb begin
		code_d = ctrl.law ? sq[17:12] : lin[11:6];
	end

	// registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_OFF;
			pos_q <= 7'h00;
			cnt_q <= 6'h00;
			code_q <= 6'h00;
		end else if (clk_en) begin
			state_q <= state_d;
			pos_q <= pos_d;
			cnt_q <= cnt_d;
			code_q <= code_d;
		end
	end

	assign sink_code = code_q;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	state_onehot_a: assert property ($onehot(state_q))
		else $error("ramp state not one-hot");
	no_fade_jump_a: assert property (
		state_q == ST_OFF && ctrl.en && fi_units == 6'h00 && clk_en
		|=> state_q == ST_ON && pos_q == `AUX_RAMP_FULL)
		else $error("no-fade enable did not jump to full");
	full_level_a: assert property (
		state_q == ST_ON && clk_en |=> code_q == $past(ctrl.level))
		else $error("full ramp does not show level");
	off_zero_a: assert property (
		state_q == ST_OFF && clk_en |=> code_q == 6'h00)
		else $error("disabled sink code not zero");
	rise_hold_a: assert property (
		state_q == ST_RISE && ctrl.en && fi_units != 6'h00 && !sub_tick
		|=> pos_q == $past(pos_q))
		else $error("ramp stepped without tick");
	fall_start_a: assert property (
		state_q == ST_ON && !ctrl.en && fo_units != 6'h00 && clk_en
		|=> state_q == ST_FALL && pos_q == `AUX_RAMP_FULL)
		else $error("disable did not start fade-out");
	fall_step_a: assert property (
		state_q == ST_FALL && !ctrl.en && sub_tick && clk_en &&
		cnt_q + 6'h01 >= fo_units && fo_units != 6'h00
		|=> pos_q == $past(pos_q) - 7'h01)
		else $error("fade-out step missing");
	freeze_a: assert property (
		!clk_en |=> $stable(pos_q) && $stable(code_q) && $stable(state_q))
		else $error("state moved with clock enable low");

	rise_done_c: cover property (state_q == ST_RISE ##1 state_q == ST_ON);
	fall_done_c: cover property (state_q == ST_FALL ##1 state_q == ST_OFF);
	reverse_c: cover property (state_q == ST_FALL ##1 state_q == ST_RISE);
	square_c: cover property (ctrl.law && state_q == ST_RISE && sub_tick);

endmodule : aux_sink_ramp

//--- core/aux_aux_fade_durations_current_regs.sv
`timescale 1ns/100ps
`include "aux_led_defines.svh"

// Function
// - fade-out code in bits 7..4; zero no fade, 0.3 s steps then 0.5 s
// - fade-in code in bits 3..0, same duration table as fade-out
// - sink 0 keeps a six-bit level in bits 5..0, upper bits unused
// - sink 1 keeps a six-bit level in bits 5..0, upper bits unused
// - sink 2 keeps a six-bit level in bits 5..0, upper bits unused
// - each sink has an enable; set starts fade-in, clear starts fade-out
// - one shared bit picks linear or square ramp shape for all sinks
module aux_aux_fade_durations_current_regs
	import aux_led_pkg::*;
#(
	parameter int unsigned SUBTICK_CYC = `AUX_SUBTICK_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic [2:0][5:0] sink_code
);

	// ****************************************
	// register file
	// ****************************************
	logic law_q, law_d;
	logic [2:0] en_q, en_d;
	logic [3:0] fo_q, fo_d, fi_q, fi_d;
	level_t [2:0] lvl_q, lvl_d;
	logic [7:0] rdata_q, rdata_d;
	logic [17:0] tick_cnt_q, tick_cnt_d;
	logic sub_tick;
	logic wr_go;
	logic rd_go;

	assign wr_go = reg_wr && clk_en;
	assign rd_go = reg_rd && clk_en;

	// write decode
	always_comb begin
		law_d = law_q;
		en_d = en_q;
		fo_d = fo_q;
		fi_d = fi_q;
		lvl_d = lvl_q;
		if (wr_go) begin
			case (reg_addr)
				`AUX_OFS_SINK_CTRL: begin
					law_d = reg_wdata[`AUX_LAW_BIT];
					en_d = reg_wdata[`AUX_EN_MSB:0];
				end
				`AUX_OFS_FADE: begin
					fo_d = reg_wdata[`AUX_FO_MSB:`AUX_FO_LSB];
					fi_d = reg_wdata[`AUX_FI_MSB:`AUX_FI_LSB];
				end
				`AUX_OFS_SINK0_LEVEL: begin
					lvl_d[0] = reg_wdata[`AUX_LEVEL_MSB:0];
				end
				`AUX_OFS_SINK1_LEVEL: begin
					lvl_d[1] = reg_wdata[`AUX_LEVEL_MSB:0];
				end
				`AUX_OFS_SINK2_LEVEL: begin
					lvl_d[2] = reg_wdata[`AUX_LEVEL_MSB:0];
				end
				default: begin
					law_d = law_q;
				end
			endcase
		end
	end

	// read mux, unused bits and unmapped offsets read zero
	always_comb begin
		rdata_d = rdata_q;
		if (rd_go) begin
			case (reg_addr)
				`AUX_OFS_SINK_CTRL: rdata_d = {4'h0, law_q, en_q};
				`AUX_OFS_FADE: rdata_d = {fo_q, fi_q};
				`AUX_OFS_SINK0_LEVEL: rdata_d = {2'h0, lvl_q[0]};
				`AUX_OFS_SINK1_LEVEL: rdata_d = {2'h0, lvl_q[1]};
				`AUX_OFS_SINK2_LEVEL: rdata_d = {2'h0, lvl_q[2]};
				default: rdata_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			{law_q, en_q} <= `AUX_RST_CTRL;
			{fo_q, fi_q} <= `AUX_RST_FADE;
			lvl_q <= {3{`AUX_RST_LEVEL}};
			rdata_q <= 8'h00;
		end else begin
			law_q <= law_d;
			en_q <= en_d;
			fo_q <= fo_d;
			fi_q <= fi_d;
			lvl_q <= lvl_d;
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata = rdata_q;

	// ****************************************
	// step time base
	// ****************************************
	// free-running sub tick, one pulse per 1/64 of a fade unit
	always_comb begin
		tick_cnt_d = tick_cnt_q + 18'h00001;
		if (tick_cnt_q == 18'(SUBTICK_CYC - 1)) begin
			tick_cnt_d = 18'h00000;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tick_cnt_q <= 18'h00000;
		end else if (clk_en) begin
			tick_cnt_q <= tick_cnt_d;
		end
	end

	assign sub_tick = (tick_cnt_q == 18'(SUBTICK_CYC - 1));

	// ****************************************
	// sink ramps
	// ****************************************
	// one ramp engine per sink, sharing law and fade codes
	for (genvar i = 0; i < 3; i++) begin : g_sink
		sink_ctrl_t ctrl;
		assign ctrl = {
			law_q,
			en_q[i],
			lvl_q[i],
			fi_q,
			fo_q
		};
		aux_sink_ramp u_ramp (
			.clk(clk),
			.rst_n(rst_n),
			.clk_en(clk_en),
			.sub_tick(sub_tick),
			.ctrl(ctrl),
			.sink_code(sink_code[i])
		);
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	// offsets that decode to a register, for the unmapped read check
	logic addr_hit;
	assign addr_hit = reg_addr inside {`AUX_OFS_SINK_CTRL, `AUX_OFS_FADE,
		`AUX_OFS_SINK0_LEVEL, `AUX_OFS_SINK1_LEVEL, `AUX_OFS_SINK2_LEVEL};

	// register bus writes and reads, and sub tick pulse width
	level_write_a: assert property (
		wr_go && reg_addr == `AUX_OFS_SINK0_LEVEL
		|=> lvl_q[0] == $past(reg_wdata[5:0]))
		else $error("sink 0 level not stored");
	level_unused_a: assert property (
		rd_go && reg_addr == `AUX_OFS_SINK1_LEVEL
		|=> reg_rdata[7:6] == 2'h0 && reg_rdata[5:0] == $past(lvl_q[1]))
		else $error("sink 1 level readback wrong");
	fade_read_a: assert property (
		rd_go && reg_addr == `AUX_OFS_FADE
		|=> reg_rdata == $past({fo_q, fi_q}))
		else $error("fade register readback wrong");
	tick_period_a: assert property (
		sub_tick && clk_en |=> !sub_tick)
		else $error("sub tick longer than one cycle");
	fade_out_write_a: assert property (
		wr_go && reg_addr == `AUX_OFS_FADE
		|=> fo_q == $past(reg_wdata[`AUX_FO_MSB:`AUX_FO_LSB]))
		else $error("fade-out code not stored");
	fade_in_write_a: assert property (
		wr_go && reg_addr == `AUX_OFS_FADE
		|=> fi_q == $past(reg_wdata[`AUX_FI_MSB:`AUX_FI_LSB]))
		else $error("fade-in code not stored");
	level1_write_a: assert property (
		wr_go && reg_addr == `AUX_OFS_SINK1_LEVEL
		|=> lvl_q[1] == $past(reg_wdata[`AUX_LEVEL_MSB:0]))
		else $error("sink 1 level not stored");
	level2_write_a: assert property (
		wr_go && reg_addr == `AUX_OFS_SINK2_LEVEL
		|=> lvl_q[2] == $past(reg_wdata[`AUX_LEVEL_MSB:0]))
		else $error("sink 2 level not stored");
	level0_read_a: assert property (
		rd_go && reg_addr == `AUX_OFS_SINK0_LEVEL
		|=> reg_rdata == {2'h0, $past(lvl_q[0])})
		else $error("sink 0 level readback wrong");
	level2_read_a: assert property (
		rd_go && reg_addr == `AUX_OFS_SINK2_LEVEL
		|=> reg_rdata == {2'h0, $past(lvl_q[2])})
		else $error("sink 2 level readback wrong");
	enable_write_a: assert property (
		wr_go && reg_addr == `AUX_OFS_SINK_CTRL
		|=> en_q == $past(reg_wdata[`AUX_EN_MSB:0]))
		else $error("sink enables not stored");
	law_write_a: assert property (
		wr_go && reg_addr == `AUX_OFS_SINK_CTRL
		|=> law_q == $past(reg_wdata[`AUX_LAW_BIT]))
		else $error("ramp shape bit not stored");
	ctrl_read_a: assert property (
		rd_go && reg_addr == `AUX_OFS_SINK_CTRL
		|=> reg_rdata == {4'h0, $past(law_q), $past(en_q)})
		else $error("control register readback wrong");
	unmapped_read_a: assert property (
		rd_go && !addr_hit |=> reg_rdata == 8'h00)
		else $error("unmapped offset did not read zero");

	// clock enable low holds every register
	reg_freeze_a: assert property (
		!clk_en |=> $stable(lvl_q) && $stable(en_q) && $stable(law_q) &&
		$stable(fo_q) && $stable(fi_q) && $stable(rdata_q) &&
		$stable(tick_cnt_q))
		else $error("register state moved with clock enable low");

	level2_write_c: cover property (
		wr_go && reg_addr == `AUX_OFS_SINK2_LEVEL);

endmodule : aux_aux_fade_durations_current_regs

//--- verif/tb_aux_aux_fade_durations_current_regs.sv
`timescale 1ns/100ps
`include "aux_led_defines.svh"

module tb_aux_aux_fade_durations_current_regs
	import aux_led_pkg::*;
;
	localparam int SUB = 4;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic clk_en = 1'b1;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] reg_rdata;
	logic [2:0][5:0] sink_code;
	int n_fail = 0;
	int num_checks = 0;
	int cyc = 0;

	// ****************************************
	// clock, device, watchdog
	// ****************************************
	always #4 clk = ~clk;

	aux_aux_fade_durations_current_regs #(.SUBTICK_CYC(SUB)) i_dut (
		.clk(clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata),
		.sink_code(sink_code)
	);

	// hang guard, well beyond the longest ramp sequence
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			n_fail++;
			results();
		end
	end

	// ****************************************
	// helpers
	// ****************************************
	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : results

	task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %s exp %h got %h", what, exp, got);
		end
	endtask : chk

	task automatic cycles(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cycles

	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(posedge clk);
		#1;
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(posedge clk);
		#1;
		reg_wr = 1'b0;
	endtask : wr

	task automatic rd(logic [7:0] a, logic [7:0] exp, string what);
		@(posedge clk);
		#1;
		reg_rd = 1'b1;
		reg_addr = a;
		@(posedge clk);
		#1;
		reg_rd = 1'b0;
		cycles(1);
		chk(what, exp, reg_rdata);
	endtask : rd

	// duration in tenth-second units for a fade code
	function automatic int units(logic [3:0] c);
		return (c <= 4'hA) ? 3 * c : 35 + 5 * (c - 11);
	endfunction : units

	// ramp up then down on sink 0, timing and midpoint shape
	task automatic ramp(logic [3:0] c, logic law);
		int n;
		int exp;
		int lo;
		n = 0;
		exp = 64 * units(c) * SUB;
		wr(`AUX_OFS_FADE, {c, c});
		wr(`AUX_OFS_SINK_CTRL, {4'h0, law, 3'b111});
		while (sink_code[0] !== 6'h3F && n < exp + 40) begin
			cycles(1);
			n++;
			if (n == exp / 2) begin
				lo = law ? 13 : 29;
				num_checks++;
				if (sink_code[0] < lo || sink_code[0] > lo + 4) begin
					n_fail++;
					$display("[ERR] mid code exp %0d got %0d", lo, sink_code[0]);
				end
			end
		end
		chk("rise ok", 8'h01, 8'((n >= exp - 4) && (n <= exp + 12)));
		chk("sink1 on", 8'h2A, {2'b00, sink_code[1]});
		wr(`AUX_OFS_SINK_CTRL, {4'h0, law, 3'b000});
		n = 0;
		lo = exp - (law ? 9 : 2) * units(c) * SUB - 8;
		while (sink_code[0] !== 6'h00 && n < exp + 40) begin
			cycles(1);
			n++;
		end
		chk("fall ok", 8'h01, 8'((n >= lo) && (n <= exp + 12)));
		chk("sink2 off", 8'h00, {2'b00, sink_code[2]});
		// let the fall reach zero so the next ramp starts from the bottom
		cycles(9 * units(c) * SUB + 8);
		rd(`AUX_OFS_SINK_CTRL, {4'h0, law, 3'b000}, "ctrl law");
	endtask : ramp

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		cycles(16);
		rst_n = 1'b1;
		// reset values of the five mapped registers
		rd(`AUX_OFS_SINK_CTRL, 8'h00, "ctrl rst");
		rd(`AUX_OFS_FADE, 8'h00, "fade rst");
		rd(`AUX_OFS_SINK0_LEVEL, 8'h00, "lvl0 rst");
		rd(`AUX_OFS_SINK1_LEVEL, 8'h00, "lvl1 rst");
		rd(`AUX_OFS_SINK2_LEVEL, 8'h00, "lvl2 rst");
		// upper level bits unused, fade fields full width
		wr(`AUX_OFS_SINK0_LEVEL, 8'hFF);
		wr(`AUX_OFS_SINK1_LEVEL, 8'hEA);
		wr(`AUX_OFS_SINK2_LEVEL, 8'h55);
		wr(`AUX_OFS_FADE, 8'hA5);
		wr(`AUX_OFS_SINK_CTRL, 8'hF0);
		wr(8'h12, 8'hFF);
		rd(`AUX_OFS_SINK0_LEVEL, 8'h3F, "lvl0");
		rd(`AUX_OFS_SINK1_LEVEL, 8'h2A, "lvl1");
		rd(`AUX_OFS_SINK2_LEVEL, 8'h15, "lvl2");
		rd(`AUX_OFS_FADE, 8'hA5, "fade");
		rd(`AUX_OFS_SINK_CTRL, 8'h00, "ctrl");
		rd(8'h12, 8'h00, "unmapped");
		// frozen clock enable drops a write
		clk_en = 1'b0;
		wr(`AUX_OFS_SINK2_LEVEL, 8'h3C);
		clk_en = 1'b1;
		rd(`AUX_OFS_SINK2_LEVEL, 8'h15, "frozen");
		// zero fade code jumps straight to level
		wr(`AUX_OFS_FADE, 8'h00);
		wr(`AUX_OFS_SINK_CTRL, 8'h07);
		cycles(3);
		chk("jump0", 8'h3F, {2'b00, sink_code[0]});
		chk("jump2", 8'h15, {2'b00, sink_code[2]});
		rd(`AUX_OFS_SINK_CTRL, 8'h07, "ctrl en");
		wr(`AUX_OFS_SINK0_LEVEL, 8'h10);
		cycles(3);
		chk("follow", 8'h10, {2'b00, sink_code[0]});
		wr(`AUX_OFS_SINK_CTRL, 8'h05);
		cycles(3);
		chk("drop1", 8'h00, {2'b00, sink_code[1]});
		chk("keep0", 8'h10, {2'b00, sink_code[0]});
		wr(`AUX_OFS_SINK_CTRL, 8'h00);
		wr(`AUX_OFS_SINK0_LEVEL, 8'h3F);
		cycles(3);
		// timed ramps over short, boundary and long codes
		ramp(4'h1, 1'b0);
		ramp(4'hA, 1'b0);
		ramp(4'hB, 1'b1);
		ramp(4'hF, 1'b0);
		results();
	end

endmodule : tb_aux_aux_fade_durations_current_regs
